/* sfdp_otp_pkg.sv */
/*
 Package for the parameter-table tail and secure OTP mode control.
 Holds register offsets, field positions, table byte values and opcodes.
 Assumes a single 250 MHz clock and an APB master on the register side.
*/
package sfdp_otp_pkg;
    // APB register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SEC = 8'h08;
    localparam logic [7:0] OFS_TBL_ADDR = 8'h0c;
    localparam logic [7:0] OFS_TBL_DATA = 8'h10;
    localparam logic [7:0] OFS_ACCESS = 8'h14;
    localparam logic [7:0] OFS_OTP_ADDR = 8'h18;
    // Opcodes
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_OTP_ENTER = 8'hb1;
    localparam logic [7:0] OP_OTP_EXIT = 8'hc1;
    localparam logic [7:0] OP_WR_STATUS1 = 8'h01;
    localparam logic [7:0] OP_WR_STATUS2 = 8'h31;
    localparam logic [7:0] OP_WR_SEC = 8'h2f;
    localparam logic [7:0] OP_RD_SEC = 8'h2b;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_QUAD_READ = 8'heb;
    localparam logic [7:0] OP_SFDP_READ = 8'h5a;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    // Table window covered here, table bytes 5Ch..87h
    localparam logic [7:0] TBL_FIRST = 8'h5c;
    localparam logic [7:0] TBL_LAST = 8'h87;
    localparam logic [7:0] TBL_FILL = 8'hff;
    // Suspend word fields
    localparam int PRG_RTS_LSB = 9;
    localparam logic [3:0] PRG_RTS_VAL = 4'h0;
    localparam int PRG_SUSP_LSB = 13;
    localparam logic [4:0] PRG_SUSP_CNT = 5'h1d;
    localparam int PRG_SUSP_UNIT_LSB = 18;
    localparam logic [1:0] UNIT_1US = 2'h1;
    localparam int ERS_RTS_LSB = 20;
    localparam logic [3:0] ERS_RTS_VAL = 4'h0;
    localparam int ERS_SUSP_LSB = 24;
    localparam logic [4:0] ERS_SUSP_CNT = 5'h1d;
    localparam int ERS_SUSP_UNIT_LSB = 29;
    localparam int SUSP_SUPP_BIT = 31;
    // Deep power-down word fields
    localparam int BUSY_POLL_LSB = 2;
    localparam logic [5:0] BUSY_POLL_VAL = 6'h3d;
    localparam int DPD_EXIT_CNT_LSB = 8;
    localparam logic [4:0] DPD_EXIT_CNT = 5'h02;
    localparam int DPD_UNIT_LSB = 13;
    localparam int DPD_EXIT_OP_LSB = 15;
    localparam logic [7:0] DPD_EXIT_OP = 8'hab;
    localparam int DPD_ENTER_OP_LSB = 23;
    localparam logic [7:0] DPD_ENTER_OP = 8'hb9;
    localparam int DPD_SUPP_BIT = 31;
    // Quad word fields
    localparam int QPI_DIS_LSB = 0;
    localparam logic [3:0] QPI_DIS_VAL = 4'h9;
    localparam int QPI_EN_LSB = 4;
    localparam logic [4:0] QPI_EN_VAL = 5'h01;
    localparam int CONT_SUPP_BIT = 9;
    localparam int CONT_EXIT_LSB = 10;
    localparam logic [5:0] CONT_EXIT_VAL = 6'h3d;
    localparam int CONT_ENTER_LSB = 16;
    localparam logic [3:0] CONT_ENTER_VAL = 4'hc;
    localparam int QER_LSB = 20;
    localparam logic [2:0] QER_VAL = 3'h1;
    localparam int HOLD_DIS_BIT = 23;
    // Power-up protection bit in table 2 word at 84h
    localparam int PWRUP_PROT_BIT = 2;
    // OTP region geometry
    localparam logic [23:0] OTP_LAST = 24'h0001ff;
    localparam logic [23:0] ESN_LAST = 24'h00000f;
    // Security register bits
    localparam int SEC_FACTORY_BIT = 0;
    localparam int SEC_LOCK_BIT = 1;
endpackage

/* sfdp_tail_rom.sv */
/*
 Read-only parameter-table tail: one byte per table address.
 Assumes the caller holds the address steady; output is combinational.
*/
`timescale 1ns/1ps
module sfdp_tail_rom
    import sfdp_otp_pkg::*;
(
    // Table byte address and data
    input wire logic [7:0] addr_in,
    output logic [7:0] data_out
);
    logic [31:0] w_susp;
    logic [31:0] w_dpd;
    logic [31:0] w_quad;
    logic [31:0] w_prot;
    logic [31:0] w_sel;
    logic [31:0] w_ops;

    // Suspend word 5Ch..5Fh, low byte from earlier fields
    assign w_susp = {1'b0, UNIT_1US, ERS_SUSP_CNT, ERS_RTS_VAL, UNIT_1US, PRG_SUSP_CNT,
                     PRG_RTS_VAL, 1'b1, 8'hec};
    // Suspend and resume opcodes 60h..63h
    assign w_ops = {OP_SUSPEND, OP_RESUME, OP_SUSPEND, OP_RESUME};
    // Busy polling and deep power-down 64h..67h
    assign w_dpd = {1'b0, DPD_ENTER_OP, DPD_EXIT_OP, UNIT_1US, DPD_EXIT_CNT,
                    BUSY_POLL_VAL, 2'h3};
    // Quad modes 68h..6Bh
    assign w_quad = {8'hff, 1'b0, QER_VAL, CONT_ENTER_VAL, CONT_EXIT_VAL, 1'b1,
                     QPI_EN_VAL, QPI_DIS_VAL};
    // Protection word 84h..87h, power-up unprotected
    assign w_prot = {16'hffff, 13'h0000, 1'b0, 2'h0};

    // Word select; unknown words read all ones
    assign w_sel = (addr_in[7:2] == 6'h17) ? w_susp :
                   (addr_in[7:2] == 6'h18) ? w_ops :
                   (addr_in[7:2] == 6'h19) ? w_dpd :
                   (addr_in[7:2] == 6'h1a) ? w_quad :
                   (addr_in[7:2] == 6'h1b) ? 32'h80c010e8 :
                   (addr_in[7:2] == 6'h20) ? 32'h20001700 :
                   (addr_in[7:2] == 6'h21) ? w_prot : {4{TBL_FILL}};
    // Little-endian byte pick
    assign data_out = w_sel[{addr_in[1:0], 3'b000} +: 8];
endmodule

/* sfdp_otp_ctrl.sv */
/*
 Secure OTP mode command gate with parameter-table tail reads over APB.
 Software posts opcodes to a command register; the block tracks OTP mode,
 the lock-down bit, and decides which commands are accepted.
 Assumes one clock domain and an APB3 master; no pins are driven here.
*/
`timescale 1ns/1ps
module sfdp_otp_ctrl
    import sfdp_otp_pkg::*;
#(
    parameter logic FACTORY_LOCK = 1'b0
)
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Mode and access status
    output logic otp_mode_out,
    output logic cmd_accept_out,
    output logic cmd_reject_out,
    output logic array_wr_en_out,
    output logic otp_wr_en_out
);
    logic otp_mode_r;
    logic lock_r;
    logic [7:0] tbl_addr_r;
    logic [7:0] last_op_r;
    logic [23:0] otp_addr_r;
    logic accept_r;
    logic reject_r;
    logic array_wr_r;
    logic otp_wr_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [7:0] tbl_byte;
    logic [7:0] op;

    // Access phase strobes; one wait state keeps read data registered
    wire access = psel_in && penable_in && !pready_r;
    wire wr_cmd = access && pwrite_in && (paddr_in == OFS_CMD);
    wire wr_sec = access && pwrite_in && (paddr_in == OFS_SEC);
    wire wr_tad = access && pwrite_in && (paddr_in == OFS_TBL_ADDR);
    wire wr_oad = access && pwrite_in && (paddr_in == OFS_OTP_ADDR);
    wire rd_tbl = access && !pwrite_in && (paddr_in == OFS_TBL_DATA);
    wire mapped = (paddr_in == OFS_CMD) || (paddr_in == OFS_STATUS) ||
                  (paddr_in == OFS_SEC) || (paddr_in == OFS_TBL_ADDR) ||
                  (paddr_in == OFS_TBL_DATA) || (paddr_in == OFS_ACCESS) ||
                  (paddr_in == OFS_OTP_ADDR);

    assign op = pwdata_in[7:0];

    // Opcode classes
    function automatic logic is_read_op(input logic [7:0] o);
        is_read_op = (o == OP_READ) || (o == OP_FAST_READ) || (o == OP_QUAD_READ) ||
                     (o == OP_RD_STATUS) || (o == OP_RD_SEC) || (o == OP_SFDP_READ) ||
                     (o == OP_OTP_EXIT);
    endfunction
    function automatic logic is_write_op(input logic [7:0] o);
        is_write_op = (o == OP_PROGRAM) || (o == OP_ERASE_4K);
    endfunction

    // OTP address inside the region
    wire otp_addr_ok = (otp_addr_r <= OTP_LAST);
    wire esn_addr = (otp_addr_r <= ESN_LAST);
    wire locked = lock_r || FACTORY_LOCK;

    // Command acceptance decision
    wire blk_reg_wr = otp_mode_r && ((op == OP_WR_STATUS1) || (op == OP_WR_STATUS2) ||
                      (op == OP_WR_SEC));
    wire blk_locked = otp_mode_r && locked && !is_read_op(op);
    wire blk_range = otp_mode_r && is_write_op(op) && !otp_addr_ok;
    wire cmd_ok = !blk_reg_wr && !blk_locked && !blk_range;
    wire sec_ok = !otp_mode_r && !lock_r;

    // Write permissions follow the accepted opcode
    wire arr_wr_nxt = wr_cmd && cmd_ok && is_write_op(op) && !otp_mode_r;
    wire otp_wr_nxt = wr_cmd && cmd_ok && is_write_op(op) && otp_mode_r && !locked;

    sfdp_tail_rom u_rom (
        .addr_in(tbl_addr_r),
        .data_out(tbl_byte)
    );

    // Read data mux
    wire [31:0] rd_mux = (paddr_in == OFS_CMD) ? {24'h000000, last_op_r} :
                         (paddr_in == OFS_STATUS) ? {28'h0000000, otp_wr_r, array_wr_r,
                                                     reject_r, otp_mode_r} :
                         (paddr_in == OFS_SEC) ? {30'h00000000, lock_r, FACTORY_LOCK} :
                         (paddr_in == OFS_TBL_ADDR) ? {24'h000000, tbl_addr_r} :
                         (paddr_in == OFS_TBL_DATA) ? {24'h000000, tbl_byte} :
                         (paddr_in == OFS_ACCESS) ? {30'h00000000, esn_addr, otp_addr_ok} :
                         (paddr_in == OFS_OTP_ADDR) ? {8'h00, otp_addr_r} : 32'h00000000;

    // OTP mode flag, volatile and cleared at reset
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            otp_mode_r <= 1'b0;
        else if (wr_cmd && op == OP_OTP_ENTER && cmd_ok)
            otp_mode_r <= 1'b1;
        else if (wr_cmd && op == OP_OTP_EXIT)
            otp_mode_r <= 1'b0;
    end

    // Lock-down bit only ever goes from 0 to 1
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            lock_r <= 1'b0;
        else if (wr_sec && sec_ok && pwdata_in[SEC_LOCK_BIT])
            lock_r <= 1'b1;
    end

    // Table address auto-increments per data read
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            tbl_addr_r <= TBL_FIRST;
        else if (wr_tad)
            tbl_addr_r <= pwdata_in[7:0];
        else if (rd_tbl)
            tbl_addr_r <= tbl_addr_r + 8'h01;
    end

    // OTP access address
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            otp_addr_r <= 24'h000000;
        else if (wr_oad)
            otp_addr_r <= pwdata_in[23:0];
    end

    // Command result pulses and last opcode
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            last_op_r <= 8'h00;
            accept_r <= 1'b0;
            reject_r <= 1'b0;
            array_wr_r <= 1'b0;
            otp_wr_r <= 1'b0;
        end
        else
        begin
            if (wr_cmd)
                last_op_r <= op;
            accept_r <= wr_cmd && cmd_ok;
            reject_r <= wr_cmd && !cmd_ok;
            array_wr_r <= arr_wr_nxt;
            otp_wr_r <= otp_wr_nxt;
        end
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= access;
            pslverr_r <= access && !mapped;
            prdata_r <= (access && !pwrite_in) ? rd_mux : 32'h00000000;
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign otp_mode_out = otp_mode_r;
    assign cmd_accept_out = accept_r;
    assign cmd_reject_out = reject_r;
    assign array_wr_en_out = array_wr_r;
    assign otp_wr_en_out = otp_wr_r;

    // Checks
    a_enter_otp: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && op == OP_OTP_ENTER && cmd_ok) |=> otp_mode_r)
        else $error("enter did not set otp mode");
    a_exit_otp: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && op == OP_OTP_EXIT) |=> !otp_mode_r)
        else $error("exit did not clear otp mode");
    a_locked_no_prog: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        otp_wr_r |-> !$past(locked))
        else $error("otp written while locked");
    a_reg_wr_blocked: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && otp_mode_r && op == OP_WR_SEC) |=> reject_r && !accept_r)
        else $error("security write accepted in otp mode");
    a_locked_reads_only: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && otp_mode_r && locked && !is_read_op(op)) |=> reject_r)
        else $error("non-read accepted while locked");
    a_lock_sticky: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $past(lock_r) |-> lock_r)
        else $error("lock bit cleared");
    a_array_blocked: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        array_wr_r |-> !$past(otp_mode_r))
        else $error("array write in otp mode");
    a_otp_range: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        otp_wr_r |-> $past(otp_addr_r) <= OTP_LAST)
        else $error("otp write out of range");
    a_tbl_ascend: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (rd_tbl && !wr_tad) |=> tbl_addr_r == $past(tbl_addr_r) + 8'h01)
        else $error("table address not ascending");
    a_apb_answer: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (psel_in && penable_in && !pready_r) |=> pready_r ##1 !pready_r)
        else $error("apb answer timing wrong");

    // Command result pulses; each taken opcode gives exactly one verdict
    a_pulse_excl: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !(accept_r && reject_r))
        else $error("accept and reject together");
    a_accept_pulse: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && cmd_ok) |=> accept_r)
        else $error("accepted opcode gave no accept pulse");
    a_reject_pulse: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && !cmd_ok) |=> reject_r)
        else $error("blocked opcode gave no reject pulse");
    a_no_cmd_quiet: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !wr_cmd |=> (!accept_r && !reject_r))
        else $error("verdict pulse without a command");
    a_wr_needs_acc: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (array_wr_r || otp_wr_r) |-> accept_r)
        else $error("write enable without accept");
    a_wr_excl: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !(array_wr_r && otp_wr_r))
        else $error("array and otp write together");
    a_otp_wr_mode: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        otp_wr_r |-> $past(otp_mode_r))
        else $error("otp write outside otp mode");
    a_array_wr_src: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        array_wr_r |-> $past(wr_cmd && is_write_op(op)))
        else $error("array write without program or erase");

    // Register writes that the OTP mode must swallow
    a_stat1_blocked: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && otp_mode_r && op == OP_WR_STATUS1) |=> reject_r)
        else $error("status write 1 accepted in otp mode");
    a_stat2_blocked: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && otp_mode_r && op == OP_WR_STATUS2) |=> reject_r)
        else $error("status write 2 accepted in otp mode");
    a_sec_otp_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_sec && otp_mode_r) |=> lock_r == $past(lock_r))
        else $error("security bits changed in otp mode");
    a_lock_set: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_sec && !otp_mode_r && pwdata_in[SEC_LOCK_BIT]) |=> lock_r)
        else $error("lock write did not set lock");
    a_lock_rise_src: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $rose(lock_r) |-> $past(wr_sec))
        else $error("lock set without security write");
    a_locked_no_wr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        locked |-> !otp_wr_nxt)
        else $error("otp write armed while locked");
    a_range_reject: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && otp_mode_r && is_write_op(op) && !otp_addr_ok) |=> reject_r && !otp_wr_r)
        else $error("otp write beyond region accepted");
    a_esn_in_otp: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        esn_addr |-> otp_addr_ok)
        else $error("serial number area outside region");

    // Mode flag moves only on its two opcodes
    a_mode_rise_src: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $rose(otp_mode_r) |-> $past(wr_cmd && op == OP_OTP_ENTER))
        else $error("otp mode set without enter");
    a_mode_fall_src: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $fell(otp_mode_r) |-> $past(wr_cmd && op == OP_OTP_EXIT))
        else $error("otp mode cleared without exit");
    a_exit_accept: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && op == OP_OTP_EXIT) |=> accept_r)
        else $error("exit opcode not accepted");
    a_enter_fresh: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (wr_cmd && op == OP_OTP_ENTER && !otp_mode_r) |=> otp_mode_r)
        else $error("enter from main array refused");
    a_mode_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !wr_cmd |=> otp_mode_r == $past(otp_mode_r))
        else $error("otp mode changed without command");
    a_last_op: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        wr_cmd |=> last_op_r == $past(op))
        else $error("last opcode not captured");

    // Address registers hold unless written or stepped
    a_tbl_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (!rd_tbl && !wr_tad) |=> tbl_addr_r == $past(tbl_addr_r))
        else $error("table address moved on its own");
    a_tbl_load: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        wr_tad |=> tbl_addr_r == $past(pwdata_in[7:0]))
        else $error("table address write lost");
    a_oad_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !wr_oad |=> otp_addr_r == $past(otp_addr_r))
        else $error("otp address moved on its own");

    // Bus answer shape; read data is zero outside the answer cycle
    a_ready_src: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        pready_r |-> $past(access))
        else $error("ready without access");
    a_ready_one: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        pready_r |=> !pready_r)
        else $error("ready longer than one cycle");
    a_err_with_rdy: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        pslverr_r |-> pready_r)
        else $error("error without ready");
    a_unmapped_err: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (access && !mapped) |=> pslverr_r)
        else $error("unmapped access without error");
    a_rdata_idle: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !pready_r |-> prdata_r == 32'h00000000)
        else $error("read data outside answer cycle");
    a_wr_rdata_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (pready_r && $past(pwrite_in)) |-> prdata_r == 32'h00000000)
        else $error("read data on a write answer");
endmodule

/* host_apb_model.sv */
/*
 Host-side model: an APB master that posts opcodes and register accesses.
 Assumes tb_top holds the fails counter and finish_test for a stalled slave.
*/
`timescale 1ns/1ps
module host_apb_model
(
    // Clock
    input wire logic clk_in,
    // Request side
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [7:0] paddr_out,
    output logic [31:0] pwdata_out,
    // Answer side
    input wire logic [31:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in
);
    // Idle bus from time zero
    initial
    begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h0;
    end

    // One transfer, held until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= wr;
        paddr_out <= a;
        pwdata_out <= wd;
        @(posedge clk_in);
        penable_out <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (pready_in !== 1'b1 && n < 50);
        rd = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // Released address and data lines flip so stale values cannot pass for held ones
        paddr_out <= ~a;
        pwdata_out <= ~wd;
        // Stalled slave: give up instead of hanging
        if (n >= 50)
        begin
            tb_top.fails++;
            tb_top.finish_test();
        end
    endtask
endmodule

/* tb_top.sv */
/*
 Self-checking bench for the OTP mode gate and the parameter-table tail.
 Assumes the host model drives the APB side and one 250 MHz clock.
*/
`timescale 1ns/1ps
module tb_top
    import sfdp_otp_pkg::*;
;
    logic mclk_in, rst_b_in, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic otp_mode, acc, rej, arr_wr, otp_wr, err;
    logic [3:0] seen;
    int fails, checks;
    // Expected table bytes 5Ch..6Fh, then 80h..87h
    localparam logic [7:0] TBL_A [20] = '{8'hec, 8'ha1, 8'h07, 8'h3d, 8'h7a, 8'h75, 8'h7a,
        8'h75, 8'hf7, 8'ha2, 8'hd5, 8'h5c, 8'h19, 8'hf6, 8'h1c, 8'hff, 8'he8, 8'h10,
        8'hc0, 8'h80};
    localparam logic [7:0] TBL_B [8] = '{8'h00, 8'h17, 8'h00, 8'h20, 8'h00, 8'h00, 8'hff,
        8'hff};
    localparam logic [23:0] OA [4] = '{24'h00000f, 24'h000010, 24'h0001ff, 24'h000200};
    localparam logic [1:0] AX [4] = '{2'h3, 2'h1, 2'h1, 2'h0};

    sfdp_otp_ctrl dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .otp_mode_out(otp_mode), .cmd_accept_out(acc), .cmd_reject_out(rej),
        .array_wr_en_out(arr_wr), .otp_wr_en_out(otp_wr));
    host_apb_model host (.clk_in(mclk_in), .psel_out(psel), .penable_out(penable),
        .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
        .pready_in(pready), .pslverr_in(pslverr));

    // Clock, 4 ns period
    initial
    begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    // Sticky capture of command pulses; only writes when a pulse is seen
    always @(posedge mclk_in)
    begin
        if (|{acc, rej, arr_wr, otp_wr})
            seen <= seen | {acc, rej, arr_wr, otp_wr};
    end

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic finish_test();
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic do_reset();
        rst_b_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        chk("otp_mode_in_reset", 32'h0, {31'h0, otp_mode});
        rst_b_in <= 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
        chk("write_err", 32'h0, {31'h0, err});
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, rd, err);
        chk(what, e, rd);
        chk("read_err", 32'h0, {31'h0, err});
    endtask

    // Post an opcode; pulses expected as {accept, reject, array, otp}
    task automatic cmd(input logic [7:0] op, input logic [3:0] e);
        seen = 4'h0;
        wr(OFS_CMD, {24'h0, op});
        repeat (3) @(posedge mclk_in);
        chk("cmd_pulses", {28'h0, e}, {28'h0, seen});
    endtask

    task automatic t_idle();
        chk("otp_mode", 32'h0, {31'h0, otp_mode});
        rdc("status", OFS_STATUS, 32'h0);
        rdc("sec", OFS_SEC, 32'h0);
    endtask

    // Whole tail in ascending order, with reserved gaps and one byte past
    task automatic t_table();
        logic [7:0] e;
        wr(OFS_TBL_ADDR, 32'h5c);
        for (int a = 'h5c; a <= 'h88; a++)
        begin
            e = (a <= 'h6f) ? TBL_A[a - 'h5c] : ((a >= 'h80 && a <= 'h87) ? TBL_B[a - 'h80]
                : TBL_FILL);
            rdc("table_byte", OFS_TBL_DATA, {24'h0, e});
        end
    endtask

    task automatic t_access();
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_OTP_ADDR, {8'h0, OA[i]});
            rdc("access", OFS_ACCESS, {30'h0, AX[i]});
        end
    endtask

    task automatic t_otp_mode();
        wr(OFS_OTP_ADDR, 32'h1ff);
        cmd(OP_OTP_ENTER, 4'b1000);
        chk("otp_mode", 32'h1, {31'h0, otp_mode});
        cmd(OP_WR_STATUS1, 4'b0100);
        cmd(OP_WR_STATUS2, 4'b0100);
        cmd(OP_WR_SEC, 4'b0100);
        wr(OFS_SEC, 32'h2);
        rdc("sec_in_otp", OFS_SEC, 32'h0);
        cmd(OP_PROGRAM, 4'b1001);
        wr(OFS_OTP_ADDR, 32'h200);
        cmd(OP_ERASE_4K, 4'b0100);
        cmd(OP_OTP_EXIT, 4'b1000);
        chk("otp_mode", 32'h0, {31'h0, otp_mode});
        cmd(OP_PROGRAM, 4'b1010);
    endtask

    task automatic t_lock();
        wr(OFS_SEC, 32'h2);
        rdc("sec_lock", OFS_SEC, 32'h2);
        wr(OFS_SEC, 32'h0);
        rdc("sec_frozen", OFS_SEC, 32'h2);
        wr(OFS_OTP_ADDR, 32'h10);
        cmd(OP_OTP_ENTER, 4'b1000);
        cmd(OP_READ, 4'b1000);
        cmd(OP_RD_SEC, 4'b1000);
        cmd(OP_PROGRAM, 4'b0100);
        cmd(OP_ERASE_4K, 4'b0100);
        cmd(OP_SUSPEND, 4'b0100);
        cmd(OP_OTP_EXIT, 4'b1000);
    endtask

    // Reset in mid-run drops the mode flag
    task automatic t_rereset();
        cmd(OP_OTP_ENTER, 4'b1000);
        do_reset();
        t_idle();
    endtask

    task automatic t_unmapped();
        host.xfer(1'b0, 8'h40, 32'h0, rd, err);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        host.xfer(1'b1, 8'h40, 32'h1, rd, err);
        chk("unmapped_wr_err", 32'h1, {31'h0, err});
    endtask

    // Main sequence
    initial
    begin
        rst_b_in = 1'b0;
        seen = 4'h0;
        fails = 0;
        checks = 0;
        do_reset();
        t_idle();
        t_table();
        t_access();
        t_otp_mode();
        t_lock();
        t_rereset();
        t_unmapped();
        finish_test();
    end
endmodule
